// >>> verilog/rcc_cfg.svh
`ifndef RCC_CFG_SVH
`define RCC_CFG_SVH
// Register indexes; byte address is four times the index
`define RCC_IDX_INDIRECT_DATA    4'h0
`define RCC_IDX_TIMER_COUNT      4'h1
`define RCC_IDX_PC_LOW           4'h2
`define RCC_IDX_CPU_FLAGS        4'h3
`define RCC_IDX_INDIRECT_POINTER 4'h4
`define RCC_IDX_CLOCK_TRIM       4'h5
`define RCC_IDX_PORT_PINS        4'h6
`define RCC_IDX_COMPARATOR_CTRL  4'h7
`define RCC_IDX_PIN_DIRECTION    4'h8
`define RCC_IDX_RESET_CAUSE      4'h9
// Flag register fields
`define RCC_FLAG_PIN_WAKE        7
`define RCC_FLAG_CMP_WAKE        6
`define RCC_FLAG_TIMEOUT_N       4
`define RCC_FLAG_POWER_DOWN_N    3
// Comparator control fields
`define RCC_CMP_OUT_BIT          7
`define RCC_CMP_ON_BIT           3
`define RCC_CMP_WAKE_DIS_BIT     0
// Configuration word fields
`define RCC_CFG_RESET_PIN_BIT    4
`define RCC_CFG_CODE_PROT_BIT    3
`define RCC_CFG_WDT_EN_BIT       2
`define RCC_CFG_USED_MASK        12'h01C
// Reset values
`define RCC_RST_PC_LOW           8'hFF
`define RCC_RST_FLAGS            8'h18
`define RCC_RST_CLOCK_TRIM       8'hFE
`define RCC_RST_CMP_CTRL         8'hFF
`define RCC_RST_PIN_DIRECTION    4'hF
`define RCC_RST_POINTER_TOP      3'h7
`define RCC_RST_UNKNOWN          8'h00
// Timing
`define RCC_SYS_CLK_HZ           20000000
`define RCC_OSC_HZ               4000000
`define RCC_OSC_DIV              (`RCC_SYS_CLK_HZ / `RCC_OSC_HZ)
`endif

// >>> verilog/rcc_pkg.sv
package rcc_pkg;
   typedef enum logic [2:0] {
      KIND_NONE      = 3'h0,
      KIND_EXT_RUN   = 3'h1,
      KIND_EXT_SLEEP = 3'h2,
      KIND_WDT_RUN   = 3'h3,
      KIND_WDT_SLEEP = 3'h4,
      KIND_PIN_WAKE  = 3'h5,
      KIND_CMP_WAKE  = 3'h6,
      KIND_POWER_ON  = 3'h7
   } rcc_kind_t;
   typedef enum logic [1:0] {
      ST_FETCH = 2'h0,
      ST_RUN   = 2'h1,
      ST_SLEEP = 2'h2
   } rcc_state_t;
endpackage : rcc_pkg

// >>> verilog/rcc_sync.sv
`timescale 1ns/100ps
module rcc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   initial begin
      if (WIDTH < 1) $error("rcc_sync: WIDTH must be at least 1");
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : rcc_sync

// >>> verilog/rcc_cause.sv
`timescale 1ns/100ps
// Sorts one cycle's events into a reset kind, external pin first
module rcc_cause (
   input  wire logic               sleeping,
   input  wire logic               ext_event,
   input  wire logic               wdt_event,
   input  wire logic               pin_event,
   input  wire logic               cmp_event,
   output rcc_pkg::rcc_kind_t      kind
);
   always_comb begin
      kind = rcc_pkg::KIND_NONE;
      if (ext_event) begin
         kind = sleeping ? rcc_pkg::KIND_EXT_SLEEP : rcc_pkg::KIND_EXT_RUN;
      end else if (wdt_event) begin
         kind = sleeping ? rcc_pkg::KIND_WDT_SLEEP : rcc_pkg::KIND_WDT_RUN;
      end else if (sleeping && pin_event) begin
         kind = rcc_pkg::KIND_PIN_WAKE;
      end else if (sleeping && cmp_event) begin
         kind = rcc_pkg::KIND_CMP_WAKE;
      end
   end
endmodule : rcc_cause

// >>> verilog/rcc_top.sv
// Contract
// [RULE1] Enabled comparator keeps running during sleep
// [RULE2] Power-on loads comparator control reset value
// [RULE3] Comparator control all ones, kept otherwise
// [RULE4] Config word 12 bits, unused bits zero
// [RULE5] Config bit 4 selects reset pin function
// [RULE6] Config bit 3 zero enables code protection
// [RULE7] Config bit 2 alone enables watchdog
// [RULE8] Config word has no program address
// [RULE9] Internal oscillator only, nominal 4 MHz
// [RULE10] Start at last address, then wrap to zero
// [RULE11] Calibration word readable despite code protection
// [RULE12] Trim register tunes oscillator, power-on FEh
// [RULE13] Accumulator bits 7:2 get calibration value
// [RULE14] Seven distinct reset kinds are classified
// [RULE15] Sleep resets keep registers, others restore
// [RULE16] Data, timer, port kept on non-power-on resets
// [RULE17] Power-on flags read 00-1 1xxx
// [RULE18] Running external reset clears wake flags only
// [RULE19] Sleep reset clears wakes, power-down; timeout by kind
// [RULE20] Running watchdog clears wakes and timeout
// [RULE21] Pin wake sets pin flag and timeout
// [RULE22] Comparator wake sets its flag and timeout
`timescale 1ns/100ps
`include "rcc_cfg.svh"
module rcc_top #(
   parameter int PROG_ADDR_W = 8
) (
   input  wire logic                   sys_clk,
   input  wire logic                   rst_n,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [7:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   input  wire logic [11:0]            config_strap,
   input  wire logic                   shared_pin_three,
   input  wire logic                   comparator_out,
   input  wire logic                   watchdog_timeout,
   input  wire logic                   pin_change,
   input  wire logic                   comparator_change,
   input  wire logic                   sleep_enter,
   input  wire logic [11:0]            calib_word,
   input  wire logic [PROG_ADDR_W-1:0] prog_read_addr,
   output logic                        prog_read_allow,
   output logic [PROG_ADDR_W-1:0]      program_counter,
   output logic [7:0]                  accumulator,
   output logic                        core_reset,
   output logic                        core_run,
   output logic                        core_clk_en,
   output logic [7:0]                  clock_trim_out,
   output logic                        comparator_power,
   output logic                        watchdog_run,
   output logic                        code_protect_on,
   output logic                        reset_pin_select,
   output logic                        pin_three_in
);
   localparam logic [PROG_ADDR_W-1:0] LAST_ADDR = '1;
   localparam int DIV = `RCC_OSC_DIV;
   localparam int DIV_W = $clog2(DIV);

   initial begin
      if (PROG_ADDR_W < 8 || PROG_ADDR_W > 12) $error("rcc_top: PROG_ADDR_W out of range");
      if (DIV < 2) $error("rcc_top: system clock too slow for oscillator rate");
   end

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [1:0] pins_sync;
   logic       ext_reset_n;
   logic       cmp_out_s;
   logic       ext_prev_reg;

   rcc_sync #(
      .WIDTH    (2)
   ) u_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in ({shared_pin_three, comparator_out}),
      .sync_out (pins_sync)
   );
   assign ext_reset_n = pins_sync[1];
   assign cmp_out_s   = pins_sync[0];

   // ==========================================================
   // Configuration word, captured once after power-on
   // ==========================================================
   logic [11:0] cfg_reg;
   logic        cfg_done_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg      <= 12'h000;
         cfg_done_reg <= 1'b0;
      end else if (!cfg_done_reg) begin
         cfg_reg      <= config_strap & `RCC_CFG_USED_MASK; // [RULE4]
         cfg_done_reg <= 1'b1;
      end
   end

   // No bus index decodes to the configuration word
   assign reset_pin_select = cfg_reg[`RCC_CFG_RESET_PIN_BIT]; // [RULE8]
   assign code_protect_on  = ~cfg_reg[`RCC_CFG_CODE_PROT_BIT]; // [RULE6]
   assign watchdog_run     = cfg_reg[`RCC_CFG_WDT_EN_BIT]; // [RULE7]
   assign pin_three_in     = ext_reset_n;

   always_comb begin
      prog_read_allow = ~code_protect_on | (prog_read_addr == LAST_ADDR); // [RULE11]
   end

   // ==========================================================
   // Event sources and classification
   // ==========================================================
   rcc_pkg::rcc_state_t state_reg;
   rcc_pkg::rcc_kind_t  kind;
   logic                ext_event;
   logic                wdt_event;
   logic                cmp_event;
   logic                sleeping;
   logic [7:0]          cmp_ctrl_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_prev_reg <= 1'b1;
      end else begin
         ext_prev_reg <= ext_reset_n;
      end
   end

   // Pin acts as reset only when selected; otherwise internal reset idle
   assign ext_event = reset_pin_select & ext_prev_reg & ~ext_reset_n; // [RULE5]
   assign wdt_event = watchdog_run & watchdog_timeout; // [RULE7]
   assign cmp_event = comparator_change & ~cmp_ctrl_reg[`RCC_CMP_WAKE_DIS_BIT];
   assign sleeping  = (state_reg == rcc_pkg::ST_SLEEP);

   rcc_cause u_cause (
      .sleeping  (sleeping),
      .ext_event (ext_event),
      .wdt_event (wdt_event),
      .pin_event (pin_change),
      .cmp_event (cmp_event),
      .kind      (kind) // [RULE14]
   );

   logic any_reset;
   logic restore;
   assign any_reset = (kind != rcc_pkg::KIND_NONE);
   assign restore   = any_reset && kind != rcc_pkg::KIND_EXT_SLEEP
                      && kind != rcc_pkg::KIND_WDT_SLEEP; // [RULE15]

   // ==========================================================
   // Core sequencing
   // ==========================================================
   logic [PROG_ADDR_W-1:0] pc_reg;
   logic [7:0]             acc_reg;
   logic                   core_reset_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= rcc_pkg::ST_FETCH;
      end else if (any_reset) begin
         state_reg <= rcc_pkg::ST_FETCH;
      end else begin
         unique case (state_reg)
            rcc_pkg::ST_FETCH: begin
               state_reg <= rcc_pkg::ST_RUN;
            end
            rcc_pkg::ST_RUN: begin
               if (sleep_enter) state_reg <= rcc_pkg::ST_SLEEP;
            end
            rcc_pkg::ST_SLEEP: begin
               state_reg <= rcc_pkg::ST_SLEEP;
            end
            default: begin
               state_reg <= rcc_pkg::ST_FETCH;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_reg <= LAST_ADDR;
      end else if (any_reset) begin
         pc_reg <= LAST_ADDR; // [RULE10]
      end else if (state_reg == rcc_pkg::ST_FETCH) begin
         pc_reg <= '0; // [RULE10]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_reg <= `RCC_RST_UNKNOWN;
      end else if (state_reg == rcc_pkg::ST_FETCH && !any_reset) begin
         acc_reg <= calib_word[7:0]; // [RULE13]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_reset_reg <= 1'b1;
      end else begin
         core_reset_reg <= any_reset;
      end
   end

   assign program_counter = pc_reg;
   assign accumulator     = acc_reg;
   assign core_reset      = core_reset_reg;
   assign core_run        = (state_reg == rcc_pkg::ST_RUN);

   // ==========================================================
   // Internal oscillator rate enable
   // ==========================================================
   logic [DIV_W-1:0] div_reg;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg     <= '0;
         core_clk_en <= 1'b0;
      end else if (div_reg == DIV_W'(DIV - 1)) begin
         div_reg     <= '0;
         core_clk_en <= ~sleeping; // [RULE9]
      end else begin
         div_reg     <= div_reg + DIV_W'(1);
         core_clk_en <= 1'b0;
      end
   end

   // ==========================================================
   // Wishbone slave
   // ==========================================================
   logic [3:0] idx;
   logic       wr;
   logic [7:0] wbyte;
   logic       ack_reg;
   logic [7:0] rd_next;

   assign idx   = wb_adr_i[5:2];
   assign wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~ack_reg
                  & (wb_adr_i[7:6] == 2'h0);
   assign wbyte = wb_dat_i[7:0];

   function automatic logic hit(input logic [3:0] a, input logic [3:0] want);
      hit = (a == want);
   endfunction : hit

   // ==========================================================
   // Register file
   // ==========================================================
   logic [7:0] ind_data_reg;
   logic [7:0] timer_reg;
   logic [7:0] flags_reg;
   logic [7:0] pointer_reg;
   logic [7:0] trim_reg;
   logic [3:0] port_reg;
   logic [3:0] dir_reg;
   logic [2:0] cause_reg;

   // Of all resets, only power-on touches these; bus writes still load them
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ind_data_reg <= `RCC_RST_UNKNOWN; // [RULE16]
         timer_reg    <= `RCC_RST_UNKNOWN;
         port_reg     <= 4'h0;
      end else if (wr) begin
         if (hit(idx, `RCC_IDX_INDIRECT_DATA)) ind_data_reg <= wbyte;
         if (hit(idx, `RCC_IDX_TIMER_COUNT)) timer_reg <= wbyte;
         if (hit(idx, `RCC_IDX_PORT_PINS)) port_reg <= wbyte[3:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         trim_reg <= `RCC_RST_CLOCK_TRIM; // [RULE12]
      end else if (wr && hit(idx, `RCC_IDX_CLOCK_TRIM)) begin
         trim_reg <= wbyte; // [RULE12]
      end
   end
   assign clock_trim_out = trim_reg;

   // Output bit is live from the comparator, never stored
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_ctrl_reg <= `RCC_RST_CMP_CTRL; // [RULE2] [RULE3]
      end else if (wr && hit(idx, `RCC_IDX_COMPARATOR_CTRL)) begin
         cmp_ctrl_reg <= {1'b1, wbyte[6:0]};
      end
   end
   // Sleep does not gate the comparator supply
   assign comparator_power = cmp_ctrl_reg[`RCC_CMP_ON_BIT]; // [RULE1]

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pointer_reg <= {`RCC_RST_POINTER_TOP, 5'h00};
         dir_reg     <= `RCC_RST_PIN_DIRECTION;
      end else if (restore) begin
         pointer_reg <= {`RCC_RST_POINTER_TOP, pointer_reg[4:0]}; // [RULE15]
         dir_reg     <= `RCC_RST_PIN_DIRECTION; // [RULE15]
      end else if (wr) begin
         if (hit(idx, `RCC_IDX_INDIRECT_POINTER)) pointer_reg <= {3'h7, wbyte[4:0]};
         if (hit(idx, `RCC_IDX_PIN_DIRECTION)) dir_reg <= wbyte[3:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cause_reg <= rcc_pkg::KIND_POWER_ON;
      end else if (any_reset) begin
         cause_reg <= kind;
      end
   end

   // Hardware reset events win over a same-cycle software write
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= `RCC_RST_FLAGS; // [RULE17]
      end else begin
         unique case (kind)
            rcc_pkg::KIND_EXT_RUN: begin
               flags_reg[7:6] <= 2'h0; // [RULE18]
            end
            rcc_pkg::KIND_EXT_SLEEP: begin
               flags_reg[7:3] <= 5'h02; // [RULE19]
            end
            rcc_pkg::KIND_WDT_SLEEP: begin
               flags_reg[7:3] <= 5'h00; // [RULE19]
            end
            rcc_pkg::KIND_WDT_RUN: begin
               flags_reg[7:6] <= 2'h0; // [RULE20]
               flags_reg[`RCC_FLAG_TIMEOUT_N] <= 1'b0; // [RULE20]
            end
            rcc_pkg::KIND_PIN_WAKE: begin
               flags_reg[7:3] <= 5'h12; // [RULE21]
            end
            rcc_pkg::KIND_CMP_WAKE: begin
               flags_reg[7:3] <= 5'h0A; // [RULE22]
            end
            default: begin
               if (state_reg == rcc_pkg::ST_RUN && sleep_enter) begin
                  flags_reg[`RCC_FLAG_TIMEOUT_N]    <= 1'b1;
                  flags_reg[`RCC_FLAG_POWER_DOWN_N] <= 1'b0;
               end
               if (wr && hit(idx, `RCC_IDX_CPU_FLAGS)) begin
                  flags_reg[7:6] <= wbyte[7:6];
                  flags_reg[2:0] <= wbyte[2:0];
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Read path and acknowledge
   // ==========================================================
   always_comb begin
      rd_next = 8'h00;
      if (wb_adr_i[7:6] == 2'h0) begin
         unique case (idx)
            `RCC_IDX_INDIRECT_DATA:    rd_next = ind_data_reg;
            `RCC_IDX_TIMER_COUNT:      rd_next = timer_reg;
            `RCC_IDX_PC_LOW:           rd_next = pc_reg[7:0];
            `RCC_IDX_CPU_FLAGS:        rd_next = {flags_reg[7:6], 1'b0, flags_reg[4:0]};
            `RCC_IDX_INDIRECT_POINTER: rd_next = pointer_reg;
            `RCC_IDX_CLOCK_TRIM:       rd_next = trim_reg;
            `RCC_IDX_PORT_PINS:        rd_next = {4'h0, port_reg};
            `RCC_IDX_COMPARATOR_CTRL:  rd_next = {cmp_out_s, cmp_ctrl_reg[6:0]};
            `RCC_IDX_RESET_CAUSE:      rd_next = {5'h00, cause_reg};
            default:                   rd_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg  <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         ack_reg  <= wb_cyc_i & wb_stb_i & ~ack_reg;
         wb_dat_o <= {24'h000000, rd_next};
      end
   end
   assign wb_ack_o = ack_reg;

endmodule : rcc_top

// >>> tb/rcc_top_asserts.sv
`timescale 1ns/100ps
module rcc_top_chk #(
   parameter int PROG_ADDR_W = 8
) (
   input wire logic                   sys_clk,
   input wire logic                   rst_n,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_we_i,
   input wire logic [7:0]             wb_adr_i,
   input wire logic [3:0]             wb_sel_i,
   input wire logic [31:0]            wb_dat_i,
   input wire logic                   wb_ack_o,
   input wire logic                   watchdog_timeout,
   input wire logic                   sleep_enter,
   input wire logic [11:0]            calib_word,
   input wire logic [PROG_ADDR_W-1:0] prog_read_addr,
   input wire logic                   prog_read_allow,
   input wire logic [PROG_ADDR_W-1:0] program_counter,
   input wire logic [7:0]             accumulator,
   input wire logic                   core_reset,
   input wire logic                   core_run,
   input wire logic                   core_clk_en,
   input wire logic [7:0]             clock_trim_out,
   input wire logic                   comparator_power,
   input wire logic                   watchdog_run,
   input wire logic                   code_protect_on,
   input wire logic                   reset_pin_select
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Bus handshake
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_trim_write: assert property (
      wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h14 && wb_sel_i[0]
      |-> clock_trim_out == wb_dat_i[7:0]) else $error("trim output not updated");
   // ==========================================
   // Start-up and configuration
   chk_pc_wrap: assert property (program_counter == '1 |=> program_counter == '0)
      else $error("program counter did not wrap to zero");
   chk_acc_calib: assert property (
      program_counter == '1 ##1 program_counter == '0 |-> accumulator == calib_word[7:0])
      else $error("accumulator lacks calibration value");
   chk_calib_open: assert property (prog_read_addr == '1 |-> prog_read_allow)
      else $error("calibration word blocked");
   chk_prot_gate: assert property (
      prog_read_addr != '1 |-> prog_read_allow == !code_protect_on)
      else $error("code protection gate wrong");
   chk_cfg_frozen: assert property (
      core_run && $past(core_run) |-> $stable({watchdog_run, code_protect_on, reset_pin_select}))
      else $error("configuration changed while running");
   chk_wdt_kick: assert property (
      core_run && watchdog_run && watchdog_timeout |-> ##[1:3] core_reset)
      else $error("watchdog timeout gave no reset");
   chk_cmp_sleep: assert property (
      core_run && sleep_enter && comparator_power |=> comparator_power [*2])
      else $error("comparator shut down in sleep");
   chk_osc_gap: assert property (core_clk_en |=> !core_clk_en [*4])
      else $error("core clock enable faster than one in five");
   cov_wdt: cover property (core_run && watchdog_run && watchdog_timeout);
   cov_sleep: cover property (core_run && sleep_enter && comparator_power);
   cov_trim: cover property (wb_ack_o && wb_we_i && wb_adr_i == 8'h14);
endmodule : rcc_top_chk

bind rcc_top rcc_top_chk #(.PROG_ADDR_W(PROG_ADDR_W)) i_chk (.*);

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i, accumulator, clock_trim_out, prog_read_addr, program_counter;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [11:0] config_strap, calib_word;
   logic        shared_pin_three, comparator_out, watchdog_timeout, pin_change;
   logic        comparator_change, sleep_enter, prog_read_allow, core_reset, core_run;
   logic        core_clk_en, comparator_power, watchdog_run, code_protect_on;
   logic        reset_pin_select, pin_three_in, exp_pw, exp_cw, exp_to, exp_pd;
   logic [7:0]  rd_q, exp_cmp;
   logic [2:0]  cfg_bits;
   int          n_fail = 0;
   int          compares = 0;

   always #25 sys_clk = ~sys_clk;

   rcc_top i_dut (.*);
   assign cfg_bits = {reset_pin_select, code_protect_on, watchdog_run};

   // ==========================================
   // Shared helpers
   task automatic finish_test();
      if (n_fail == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : expect8

   task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= {24'h000000, dat};
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      rd_q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 16) begin
         n_fail++;
         $display("CHECK FAILED t=%0t no bus ack", $time);
      end
   endtask : bus

   task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
      bus(1'b0, adr, 8'h00);
      expect8(rd_q, exp);
   endtask : rd

   // Sleeps first where the kind needs it, then raises the event
   task automatic fire(input int k);
      int n;
      n = 0;
      if (k inside {2, 4, 5, 6}) begin
         @(posedge sys_clk);
         sleep_enter <= 1'b1;
         @(posedge sys_clk);
         sleep_enter <= 1'b0;
         repeat (3) @(posedge sys_clk);
         expect8(comparator_power, exp_cmp[3]);
         expect8(core_run, 1'b0);
         exp_to = 1'b1;
         exp_pd = 1'b0;
      end
      @(posedge sys_clk);
      case (k)
         1, 2: shared_pin_three <= 1'b0;
         3, 4: watchdog_timeout <= 1'b1;
         5: pin_change <= 1'b1;
         default: comparator_change <= 1'b1;
      endcase
      @(posedge sys_clk);
      watchdog_timeout  <= 1'b0;
      pin_change        <= 1'b0;
      comparator_change <= 1'b0;
      while (core_reset !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      shared_pin_three <= 1'b1;
      repeat (4) @(posedge sys_clk);
      expect8(n < 20, 1'b1);
      exp_pw = (k == 5);
      exp_cw = (k == 6);
      if (k == 3 || k == 4) exp_to = 1'b0;
   endtask : fire

   task automatic check_state(input logic [7:0] cause);
      logic [7:0] exp_flags;
      exp_flags = {exp_pw, exp_cw, 1'b0, exp_to, exp_pd, 3'h5};
      rd(8'h24, cause);
      rd(8'h0C, exp_flags);
      rd(8'h14, 8'h5A);
      rd(8'h1C, exp_cmp);
      rd(8'h00, 8'h3C);
      rd(8'h04, 8'h96);
      rd(8'h18, 8'h06);
      rd(8'h10, 8'hEA);
      expect8(program_counter, 8'h00);
      expect8(accumulator, calib_word[7:0]);
   endtask : check_state

   // ==========================================
   // Scenarios
   task automatic t_por();
      rd(8'h0C, 8'h18);
      rd(8'h14, 8'hFE);
      rd(8'h1C, 8'hFF);
      rd(8'h24, 8'h07);
      expect8(program_counter, 8'h00);
      expect8(accumulator, calib_word[7:0]);
   endtask : t_por

   task automatic t_config();
      int n;
      n = 0;
      expect8(cfg_bits, 3'h7);
      // Core rate enable: one pulse in every five clocks
      repeat (20) begin
         @(posedge sys_clk);
         if (core_clk_en === 1'b1) n++;
      end
      expect8(n[7:0], 8'h04);
      @(posedge sys_clk);
      prog_read_addr <= 8'hFF;
      config_strap   <= 12'h008;
      @(posedge sys_clk);
      expect8(prog_read_allow, 1'b1);
      prog_read_addr <= 8'h10;
      repeat (3) @(posedge sys_clk);
      expect8(prog_read_allow, 1'b0);
      expect8(cfg_bits, 3'h7);
   endtask : t_config

   task automatic t_setup();
      bus(1'b1, 8'h00, 8'h3C);
      bus(1'b1, 8'h04, 8'h96);
      bus(1'b1, 8'h18, 8'h06);
      bus(1'b1, 8'h10, 8'h0A);
      bus(1'b1, 8'h14, 8'h5A);
      bus(1'b1, 8'h0C, 8'h05);
      bus(1'b1, 8'h40, 8'h77);
      expect8(clock_trim_out, 8'h5A);
      rd(8'h40, 8'h00);
      rd(8'h28, 8'h00);
      rd(8'h20, 8'h00);
      rd(8'h0C, 8'h1D);
   endtask : t_setup

   task automatic t_kinds();
      int ks[6] = '{3, 1, 2, 4, 5, 1};
      foreach (ks[i]) begin
         fire(ks[i]);
         check_state(ks[i][7:0]);
      end
   endtask : t_kinds

   task automatic t_cmp_wake();
      bus(1'b1, 8'h1C, 8'h08);
      exp_cmp = 8'h88;
      rd(8'h1C, exp_cmp);
      // Output bit follows the live comparator result
      comparator_out <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rd(8'h1C, 8'h08);
      comparator_out <= 1'b1;
      fire(6);
      check_state(8'h06);
   endtask : t_cmp_wake

   task automatic t_por_again();
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      exp_cmp = 8'hFF;
      t_por();
      expect8(cfg_bits, 3'h0);
      expect8(prog_read_allow, 1'b1);
      @(posedge sys_clk);
      watchdog_timeout <= 1'b1;
      shared_pin_three <= 1'b0;
      @(posedge sys_clk);
      watchdog_timeout <= 1'b0;
      repeat (5) @(posedge sys_clk);
      expect8(pin_three_in, 1'b0);
      rd(8'h24, 8'h07);
      shared_pin_three <= 1'b1;
   endtask : t_por_again

   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'h1;
      config_strap = 12'hFF4;
      calib_word = 12'hC9B;
      prog_read_addr = 8'h00;
      {shared_pin_three, comparator_out} = 2'h3;
      {watchdog_timeout, pin_change, comparator_change, sleep_enter} = 4'h0;
      {exp_pw, exp_cw, exp_to, exp_pd} = 4'h3;
      exp_cmp = 8'hFF;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_por();
      t_config();
      t_setup();
      t_kinds();
      t_cmp_wake();
      t_por_again();
      finish_test();
   end

   initial begin
      #1000000;
      n_fail++;
      $display("CHECK FAILED t=%0t run too long", $time);
      finish_test();
   end
endmodule : tb_top
